// ---- hw/kr_phy_regs_pkg.sv ----
// holds register offsets, bit positions, reset values and carrier structs
// assumes a word-addressed management port and sequencer logic on clk
package kr_phy_regs_pkg;

   // ====================================================================
   // word offsets
   localparam logic [7:0] OFF_SEQ_CTRL   = 8'hb0;
   localparam logic [7:0] OFF_SEQ_STAT   = 8'hb1;
   localparam logic [7:0] OFF_FEC_INJ    = 8'hb2;
   localparam logic [7:0] OFF_FEC_CORR   = 8'hb3;
   localparam logic [7:0] OFF_FEC_UNCORR = 8'hb4;
   localparam logic [7:0] OFF_NEG_CTRL   = 8'hc0;
   localparam logic [7:0] OFF_NEG_RST    = 8'hc1;
   localparam logic [7:0] OFF_NEG_STAT   = 8'hc2;

   // ====================================================================
   // field positions
   localparam int B_SEQ_RESET    = 0;
   localparam int B_FEC_REQUEST  = 18;
   localparam int B_LINK_READY   = 0;
   localparam int B_AN_TIMEOUT   = 1;
   localparam int B_LT_TIMEOUT   = 2;
   localparam int B_MODE_LO      = 8;
   localparam int B_FEC_ABILITY  = 16;
   localparam int B_FEC_ERR_IND  = 17;
   localparam int B_XCODE_INJ    = 0;
   localparam int B_BURST_INJ    = 1;
   localparam int B_BURST_LEN_LO = 2;
   localparam int B_INJECT       = 11;
   localparam int B_AN_ENABLE    = 0;
   localparam int B_BASE_SEL     = 1;
   localparam int B_NEXT_SEL     = 2;
   localparam int B_REMOTE_FAULT = 3;
   localparam int B_FORCE_NONCE  = 4;
   localparam int B_OVERRIDE     = 5;
   localparam int B_AN_RESET     = 0;
   localparam int B_TX_RESTART   = 4;
   localparam int B_NP_READY     = 8;
   localparam int B_PAGE_RX      = 1;
   localparam int B_AN_COMPLETE  = 2;

   // ====================================================================
   // reset values and counter maximum
   localparam logic        RST_AN_ENABLE = 1'b1;
   localparam logic [31:0] CNT_MAX       = 32'hffffffff;

   // ====================================================================
   // carriers
   typedef struct packed {
      logic       link_ready;
      logic       an_timeout;
      logic       an_restart;
      logic       lt_timeout;
      logic [5:0] reconfig_mode;
      logic       fec_corrected;
      logic       fec_uncorrected;
      logic       local_remote_fault;
      logic       page_received;
      logic       an_complete;
      logic       next_page_sent;
      logic       tx_in_an_state;
   } phy_status_t;

   typedef struct packed {
      logic       seq_reset;
      logic       fec_request_advertise;
      logic       transcoder_error_inject_enable;
      logic       encoder_burst_inject_enable;
      logic [3:0] inject_burst_length;
      logic       inject_error_pulse;
      logic       negotiation_enable;
      logic       user_base_page_select;
      logic       user_next_page_select;
      logic       force_nonce;
      logic       advertisement_override_enable;
      logic       negotiation_machines_reset;
      logic       negotiation_tx_restart;
      logic       next_page_ready;
   } phy_control_t;

   typedef struct packed {
      logic [31:0]  readdata;
      logic         readdatavalid;
      phy_control_t ctl;
      logic         negotiation_timeout_flag;
      logic         inject_bit;
      logic [31:0]  corrected;
      logic [31:0]  uncorrected;
      logic         page_rx;
   } bank_state_t;

endpackage

// ---- hw/kr_phy_seq_fec_an_control.sv ----
// control and status bank for a backplane phy lane: sequencer, fec, negotiation
// assumes status inputs come from logic on clk and a word-addressed management port
`timescale 1ns/1ps

module kr_phy_seq_fec_an_control
   import kr_phy_regs_pkg::*;
#(
   parameter int   ADDR_W        = 8,
   parameter logic FEC_SUPPORTED = 1'b1,
   parameter logic FEC_ERR_ABLE  = 1'b1
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   output      logic [31:0]       readdata,
   output      logic              readdatavalid,
   input  wire phy_status_t       status,
   output      phy_control_t      control
);

   // ====================================================================
   // elaboration checks
   if (ADDR_W < 8) begin : g_addr_chk
      $error("address too narrow for register map");
   end

   // ====================================================================
   // state
   bank_state_t st;
   bank_state_t next_st;

   assign readdata      = st.readdata;
   assign readdatavalid = st.readdatavalid;
   assign control       = st.ctl;

   // ====================================================================
   // decode helpers
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0]        off);
      hit = (a == ADDR_W'(off));
   endfunction

   function automatic logic [31:0] sat_inc(input logic [31:0] c,
                                           input logic        ev);
      // hold at maximum instead of wrapping
      if (ev && c != CNT_MAX) begin
         sat_inc = c + 32'h00000001;
      end else begin
         sat_inc = c;
      end
   endfunction

   // ====================================================================
   // read mux
   function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                             input bank_state_t       s,
                                             input phy_status_t       ev);
      logic [31:0] w;
      w = 32'h00000000;
      if (hit(a, OFF_SEQ_CTRL)) begin
         // reset bit is a pulse and reads back as zero
         w[B_FEC_REQUEST] = s.ctl.fec_request_advertise;
      end else if (hit(a, OFF_SEQ_STAT)) begin
         w[B_LINK_READY]          = ev.link_ready;
         w[B_AN_TIMEOUT]          = s.negotiation_timeout_flag;
         w[B_LT_TIMEOUT]          = ev.lt_timeout;
         w[B_MODE_LO +: 6]        = ev.reconfig_mode;
         w[B_FEC_ABILITY]         = FEC_SUPPORTED;
         w[B_FEC_ERR_IND]         = FEC_ERR_ABLE;
      end else if (hit(a, OFF_FEC_INJ)) begin
         w[B_XCODE_INJ]           = s.ctl.transcoder_error_inject_enable;
         w[B_BURST_INJ]           = s.ctl.encoder_burst_inject_enable;
         w[B_BURST_LEN_LO +: 4]   = s.ctl.inject_burst_length;
         w[B_INJECT]              = s.inject_bit;
      end else if (hit(a, OFF_FEC_CORR)) begin
         w = s.corrected;
      end else if (hit(a, OFF_FEC_UNCORR)) begin
         w = s.uncorrected;
      end else if (hit(a, OFF_NEG_CTRL)) begin
         w[B_AN_ENABLE]           = s.ctl.negotiation_enable;
         w[B_BASE_SEL]            = s.ctl.user_base_page_select;
         w[B_NEXT_SEL]            = s.ctl.user_next_page_select;
         w[B_REMOTE_FAULT]        = ev.local_remote_fault;
         w[B_FORCE_NONCE]         = s.ctl.force_nonce;
         w[B_OVERRIDE]            = s.ctl.advertisement_override_enable;
      end else if (hit(a, OFF_NEG_RST)) begin
         w[B_NP_READY]            = s.ctl.next_page_ready;
      end else if (hit(a, OFF_NEG_STAT)) begin
         w[B_PAGE_RX]             = s.page_rx;
         w[B_AN_COMPLETE]         = ev.an_complete;
      end
      read_word = w;
   endfunction

   // ====================================================================
   // next state
   always_comb begin
      next_st = st;

      // pulses last one cycle only
      next_st.readdatavalid                  = 1'b0;
      next_st.ctl.seq_reset                  = 1'b0;
      next_st.ctl.inject_error_pulse         = 1'b0;
      next_st.ctl.negotiation_machines_reset = 1'b0;
      next_st.ctl.negotiation_tx_restart     = 1'b0;

      // hardware events; set is applied after clear so it wins
      if (status.an_restart) begin
         next_st.negotiation_timeout_flag = 1'b0;
      end
      if (status.an_timeout) begin
         next_st.negotiation_timeout_flag = 1'b1;
      end
      if (status.page_received) begin
         next_st.page_rx = 1'b1;
      end
      if (status.next_page_sent) begin
         next_st.ctl.next_page_ready = 1'b0;
      end
      next_st.corrected   = sat_inc(st.corrected, status.fec_corrected);
      next_st.uncorrected = sat_inc(st.uncorrected, status.fec_uncorrected);

      if (read) begin
         next_st.readdatavalid = 1'b1;
         next_st.readdata      = read_word(address, st, status);
         // a block that arrives during the clearing read is kept
         if (hit(address, OFF_FEC_CORR)) begin
            next_st.corrected = {31'h00000000, status.fec_corrected};
         end else if (hit(address, OFF_FEC_UNCORR)) begin
            next_st.uncorrected = {31'h00000000, status.fec_uncorrected};
         end else if (hit(address, OFF_NEG_STAT)) begin
            next_st.page_rx = status.page_received;
         end
      end else if (write) begin
         if (hit(address, OFF_SEQ_CTRL)) begin
            // software must pulse reset after a change of this bit
            next_st.ctl.fec_request_advertise = writedata[B_FEC_REQUEST];
            next_st.ctl.seq_reset             = writedata[B_SEQ_RESET];
         end else if (hit(address, OFF_FEC_INJ)) begin
            next_st.ctl.transcoder_error_inject_enable = writedata[B_XCODE_INJ];
            next_st.ctl.encoder_burst_inject_enable    = writedata[B_BURST_INJ];
            next_st.ctl.inject_burst_length = writedata[B_BURST_LEN_LO +: 4];
            next_st.inject_bit              = writedata[B_INJECT];
            next_st.ctl.inject_error_pulse  = writedata[B_INJECT];
         end else if (hit(address, OFF_NEG_CTRL)) begin
            next_st.ctl.negotiation_enable    = writedata[B_AN_ENABLE];
            next_st.ctl.user_base_page_select = writedata[B_BASE_SEL];
            next_st.ctl.user_next_page_select = writedata[B_NEXT_SEL];
            next_st.ctl.force_nonce           = writedata[B_FORCE_NONCE];
            next_st.ctl.advertisement_override_enable = writedata[B_OVERRIDE];
         end else if (hit(address, OFF_NEG_RST)) begin
            next_st.ctl.negotiation_machines_reset = writedata[B_AN_RESET];
            // outside the negotiation state a restart request is dropped
            next_st.ctl.negotiation_tx_restart =
               writedata[B_TX_RESTART] & status.tx_in_an_state;
            if (writedata[B_NP_READY]) begin
               next_st.ctl.next_page_ready = 1'b1;
            end
         end
         // other offsets and reserved bits take no write
      end
   end

   // ====================================================================
   // registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st                        <= '0;
         st.ctl.negotiation_enable <= RST_AN_ENABLE;
      end else begin
         st <= next_st;
      end
   end

endmodule // kr_phy_seq_fec_an_control

// ---- sim/kr_phy_bank_checker.sv ----
// assertions on the management port and control outputs of the register bank
// assumes it is bound onto kr_phy_seq_fec_an_control, everything on clk
`timescale 1ns/1ps

module kr_phy_bank_checker
   import kr_phy_regs_pkg::*;
#(
   parameter int   ADDR_W        = 8,
   parameter logic FEC_SUPPORTED = 1'b1,
   parameter logic FEC_ERR_ABLE  = 1'b1
) (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic [ADDR_W-1:0] address,
   input wire logic              read,
   input wire logic              write,
   input wire logic [31:0]       writedata,
   input wire logic [31:0]       readdata,
   input wire logic              readdatavalid,
   input wire phy_status_t       status,
   input wire phy_control_t      control
);
   // ====================================================================
   // helpers
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic wr_ok;
   // read wins over a simultaneous write
   assign wr_ok = write && !read;

   // ====================================================================
   // properties
   property p_seq_reset;
      wr_ok && address == OFF_SEQ_CTRL && writedata[B_SEQ_RESET] |=> control.seq_reset;
   endproperty
   a_seq_reset: assert property (p_seq_reset) else $error("no sequencer restart");
   property p_an_reset;
      wr_ok && address == OFF_NEG_RST && writedata[B_AN_RESET] |=> control.negotiation_machines_reset;
   endproperty
   a_an_reset: assert property (p_an_reset) else $error("no negotiation reset");
   property p_tx_restart;
      wr_ok && address == OFF_NEG_RST && writedata[B_TX_RESTART]
         |=> control.negotiation_tx_restart == $past(status.tx_in_an_state);
   endproperty
   a_tx_restart: assert property (p_tx_restart) else $error("bad transmit restart");
   property p_inject;
      wr_ok && address == OFF_FEC_INJ && writedata[B_INJECT] |=> control.inject_error_pulse;
   endproperty
   a_inject: assert property (p_inject) else $error("no inject pulse");
   property p_inject_cause;
      control.inject_error_pulse |-> $past(wr_ok && address == OFF_FEC_INJ && writedata[B_INJECT]);
   endproperty
   a_inject_cause: assert property (p_inject_cause) else $error("stray inject pulse");
   property p_link_mode;
      read && address == OFF_SEQ_STAT |=> readdata[0] == $past(status.link_ready)
         && readdata[13:8] == $past(status.reconfig_mode);
   endproperty
   a_link_mode: assert property (p_link_mode) else $error("bad link or mode");
   property p_fec_caps;
      read && address == OFF_SEQ_STAT |=> readdata[17:16] == {FEC_ERR_ABLE, FEC_SUPPORTED};
   endproperty
   a_fec_caps: assert property (p_fec_caps) else $error("bad fec flags");
   property p_inj_reserved;
      read && address == OFF_FEC_INJ |=> readdata[10:6] == 5'h00 && readdata[31:12] == 20'h00000;
   endproperty
   a_inj_reserved: assert property (p_inj_reserved) else $error("reserved bits set");
   property p_nego_enable;
      wr_ok && address == OFF_NEG_CTRL |=> control.negotiation_enable == $past(writedata[0]);
   endproperty
   a_nego_enable: assert property (p_nego_enable) else $error("enable not stored");
   property p_fault;
      read && address == OFF_NEG_CTRL |=> readdata[3] == $past(status.local_remote_fault);
   endproperty
   a_fault: assert property (p_fault) else $error("bad remote fault bit");

   // ====================================================================
   // covers
   c_restart: cover property (wr_ok && address == OFF_NEG_RST && status.tx_in_an_state);
   c_inject: cover property (control.inject_error_pulse);
   c_count: cover property (read && address == OFF_FEC_CORR);
endmodule // kr_phy_bank_checker

// ---- sim/phy_status_model.sv ----
// sequencer and negotiation side seen by the bank: status driven from bench requests
// assumes bench drives req on clk; reacts to restart and next page controls
`timescale 1ns/1ps

module phy_status_model
   import kr_phy_regs_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire phy_status_t  req,
   input  wire phy_control_t control,
   output      phy_status_t  status
);
   // ====================================================================
   // one-cycle latency, like a registered status source
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= '0;
      end else begin
         status                <= req;
         status.an_restart     <= control.seq_reset;
         status.next_page_sent <= control.next_page_ready;
      end
   end
endmodule // phy_status_model

// ---- sim/tb_top.sv ----
// self-checking bench for the phy control and status bank
// assumes the status model stands in for sequencer and negotiation logic
`timescale 1ns/1ps

module tb_top;
   import kr_phy_regs_pkg::*;
   logic         clk, rst_n, read, write, readdatavalid;
   logic [7:0]   address;
   logic [31:0]  writedata, readdata;
   phy_status_t  req, status;
   phy_control_t control;
   int           error_cnt, n_compared;

   kr_phy_seq_fec_an_control DUT (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .readdatavalid(readdatavalid), .status(status), .control(control));
   phy_status_model PM (.clk(clk), .rst_n(rst_n), .req(req), .control(control),
      .status(status));

   // ====================================================================
   // bus and check tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      address <= a; writedata <= d; write <= 1'b1;
      @(posedge clk);
      write <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      address <= a; read <= 1'b1;
      @(posedge clk);
      read <= 1'b0;
      #1;
      chk(32'(readdatavalid), 32'h1);
      chk(readdata, exp);
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // ====================================================================
   // scenarios
   task automatic t_seq;
      req.link_ready <= 1'b1; req.lt_timeout <= 1'b1; req.reconfig_mode <= 6'h2d;
      req.an_timeout <= 1'b1;
      @(posedge clk);
      req.an_timeout <= 1'b0;
      repeat (3) @(posedge clk);
      rd(OFF_SEQ_STAT, 32'h00032d07);
      wr(OFF_SEQ_CTRL, 32'h00040001);
      chk(32'(control.seq_reset), 32'h1);
      chk(32'(control.fec_request_advertise), 32'h1);
      @(posedge clk); #1;
      chk(32'(control.seq_reset), 32'h0);
      repeat (2) @(posedge clk);
      rd(OFF_SEQ_STAT, 32'h00032d05);
   endtask
   task automatic t_inject;
      wr(OFF_FEC_INJ, 32'hffffffff);
      chk(32'(control.inject_error_pulse), 32'h1);
      chk(32'({control.transcoder_error_inject_enable, control.encoder_burst_inject_enable,
               control.inject_burst_length}), 32'h3f);
      @(posedge clk); #1;
      chk(32'(control.inject_error_pulse), 32'h0);
      rd(OFF_FEC_INJ, 32'h0000083f);
   endtask
   task automatic t_count;
      req.fec_corrected <= 1'b1;
      repeat (5) @(posedge clk);
      req.fec_corrected <= 1'b0; req.fec_uncorrected <= 1'b1;
      repeat (3) @(posedge clk);
      req.fec_uncorrected <= 1'b0;
      repeat (3) @(posedge clk);
      rd(OFF_FEC_CORR, 32'h5);
      rd(OFF_FEC_CORR, 32'h0);
      rd(OFF_FEC_UNCORR, 32'h3);
      rd(8'h55, 32'h0);
   endtask
   task automatic t_neg;
      req.local_remote_fault <= 1'b1; req.an_complete <= 1'b1;
      wr(OFF_NEG_CTRL, 32'hfffffff6);
      chk(32'({control.user_base_page_select, control.user_next_page_select,
               control.force_nonce, control.advertisement_override_enable,
               control.negotiation_enable}), 32'h1e);
      rd(OFF_NEG_CTRL, 32'h3e);
      wr(OFF_NEG_CTRL, 32'h1);
      wr(OFF_NEG_RST, 32'h11);
      chk(32'({control.negotiation_machines_reset, control.negotiation_tx_restart}), 32'h2);
      req.tx_in_an_state <= 1'b1;
      repeat (2) @(posedge clk);
      wr(OFF_NEG_RST, 32'h10);
      chk(32'({control.negotiation_machines_reset, control.negotiation_tx_restart}), 32'h1);
      wr(OFF_NEG_RST, 32'h100);
      chk(32'(control.next_page_ready), 32'h1);
      repeat (3) @(posedge clk); #1;
      chk(32'(control.next_page_ready), 32'h0);
      req.page_received <= 1'b1;
      @(posedge clk);
      req.page_received <= 1'b0;
      repeat (2) @(posedge clk);
      rd(OFF_NEG_STAT, 32'h6);
      rd(OFF_NEG_STAT, 32'h4);
   endtask

   // ====================================================================
   // clock, reset, sequence, watchdog
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0; read = 1'b0; write = 1'b0; address = 8'h00; writedata = 32'h0;
      req = '0; error_cnt = 0; n_compared = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk(32'(control.negotiation_enable), 32'h1);
      rd(OFF_NEG_CTRL, 32'h1);
      t_seq();
      t_inject();
      t_count();
      t_neg();
      stop_test();
   end
   // whole run is under a hundred cycles
   initial begin
      #(5000 * 100);
      error_cnt++;
      stop_test();
   end
endmodule // tb_top

bind kr_phy_seq_fec_an_control kr_phy_bank_checker #(.ADDR_W(ADDR_W),
   .FEC_SUPPORTED(FEC_SUPPORTED), .FEC_ERR_ABLE(FEC_ERR_ABLE)) chk_i (.clk(clk),
   .rst_n(rst_n), .address(address), .read(read), .write(write), .writedata(writedata),
   .readdata(readdata), .readdatavalid(readdatavalid), .status(status), .control(control));
